// *** ufl_consts.vh ***
// Constants for the serial control, flow control and loopback block.
// Included by the serial control design file by bare name; definitions only.
`ifndef UFL_CONSTS_VH
`define UFL_CONSTS_VH

// Register byte offsets
`define UFL_OFS_CTRL      4'h0
`define UFL_OFS_TEST      4'h4
`define UFL_OFS_STATUS    4'h8

// Control register fields
`define UFL_CR_CLEAR_TO_SEND_FLOW_EN      15
`define UFL_CR_REQUEST_TO_SEND_FLOW_EN      14
`define UFL_CR_OUT_B      13
`define UFL_CR_OUT_A      12
`define UFL_CR_RTS        11
`define UFL_CR_DTR        10
`define UFL_CR_RXE        9
`define UFL_CR_TXE        8
`define UFL_CR_LBE        7
`define UFL_CR_SIRLP      2
`define UFL_CR_INFRARED_PATH_ENABLE      1
`define UFL_CR_UEN        0
`define UFL_CR_RESET      16'h0300
`define UFL_CR_MASK       16'hff87

// Test control register fields
`define UFL_TCR_INFRARED_TEST_OVERRIDE   2
`define UFL_TCR_RESET     16'h0000
`define UFL_TCR_MASK      16'h0004

// Status register fields
`define UFL_ST_TX_RUN     0
`define UFL_ST_RX_RUN     1
`define UFL_ST_TX_ACT     2
`define UFL_ST_RX_ACT     3
`define UFL_ST_CTS        4
`define UFL_ST_DSR        5
`define UFL_ST_DCD        6
`define UFL_ST_RI         7

`endif

// *** ufl_run_gate.v ***
// Run gate for one direction of the serial engine.
// Assumes the engine raises its active flag for a whole character.
`timescale 1ns/1ps
`default_nettype none

module ufl_run_gate (
    // Clock and reset
    input  wire clk,
    input  wire resetn,
    // Control
    input  wire enable,
    input  wire char_active,
    // Result
    output reg  run_r
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_RUN   = 3'b010;
    localparam ST_DRAIN = 3'b100;

    reg [2:0] state_r;
    reg [2:0] state_nxt;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (enable) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!enable) begin
                    // Character in flight is allowed to complete
                    state_nxt = char_active ? ST_DRAIN : ST_IDLE;
                end
            end
            ST_DRAIN: begin
                if (enable) begin
                    state_nxt = ST_RUN;
                end else if (!char_active) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            run_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            run_r   <= (state_nxt != ST_IDLE);
        end
    end
endmodule

`default_nettype wire

// *** ufl_serial_ctrl.v ***
// Serial port control register, flow control, modem lines and loopback.
// Assumes an Avalon-MM master and an engine that reports active characters.
//
// Function
// (RL1) Reset clears bits, sets receive/transmit enables
// (RL2) Clear-to-send flow gates transmission on pin
// (RL3) Request-to-send flow follows receive FIFO room
// (RL4) Second auxiliary pin is inverse of bit
// (RL5) First auxiliary pin is inverse of bit
// (RL6) Request-to-send pin inverts bit unless flow
// (RL7) Terminal-ready pin is inverse of bit
// (RL8) Receive enable runs receiver, wired or infrared
// (RL9) Transmit enable runs transmitter, wired or infrared
// (RL10) Disabling receiver finishes current character first
// (RL11) Disabling transmitter finishes current character first
// (RL12) Infrared loopback inverts output into input
// (RL13) Normal loopback feeds transmit into receive
// (RL14) Loopback feeds modem outputs into inputs
// (RL15) Software clears infrared test after loopback
// (RL16) Both direction enable and port enable needed
// (RL17) Infrared mode idles wired line, ignores inputs
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ufl_consts.vh"

module ufl_serial_ctrl (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // Avalon-MM slave
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    // Serial engine side
    input  wire        core_txd,
    input  wire        core_sir_out_n,
    input  wire        tx_char_active,
    input  wire        rx_char_active,
    input  wire        rx_fifo_room,
    output reg         core_rxd,
    output reg         core_sir_in,
    output reg         tx_run,
    output reg         rx_run,
    output reg         cts_seen,
    output reg         dsr_seen,
    output reg         dcd_seen,
    output reg         ri_seen,
    output reg         infrared_path_enable,
    output reg         infrared_low_power,
    // Line pins
    input  wire        serial_rx_pin,
    input  wire        infrared_in,
    input  wire        clear_to_send_pin_n,
    input  wire        data_set_ready_pin_n,
    input  wire        carrier_detect_pin_n,
    input  wire        ring_indicator_pin_n,
    output reg         serial_tx_pin,
    output reg         infrared_out_n,
    output reg         request_to_send_pin_n,
    output reg         terminal_ready_pin_n,
    output reg         aux_output_a_pin_n,
    output reg         aux_output_b_pin_n
);
    reg  [15:0] serial_control_reg_r;
    reg  [15:0] serial_test_control_reg_r;
    wire [1:0]  run_w;
    wire [1:0]  run_en_w;
    wire [1:0]  active_w;

    wire access_w   = read | write;
    wire take_w     = access_w & ~waitrequest;
    wire port_enable             = serial_control_reg_r[`UFL_CR_UEN];
    wire sir_en_w                = serial_control_reg_r[`UFL_CR_INFRARED_PATH_ENABLE];
    wire loopback_enable         = serial_control_reg_r[`UFL_CR_LBE];
    wire transmitter_enable      = serial_control_reg_r[`UFL_CR_TXE];
    wire receiver_enable         = serial_control_reg_r[`UFL_CR_RXE];
    wire clear_to_send_flow_en   = serial_control_reg_r[`UFL_CR_CLEAR_TO_SEND_FLOW_EN];
    wire request_to_send_flow_en = serial_control_reg_r[`UFL_CR_REQUEST_TO_SEND_FLOW_EN];
    wire aux_modem_output_b      = serial_control_reg_r[`UFL_CR_OUT_B];
    wire aux_modem_output_a      = serial_control_reg_r[`UFL_CR_OUT_A];
    wire infrared_test_override  = serial_test_control_reg_r[`UFL_TCR_INFRARED_TEST_OVERRIDE];

    // Apply byte enables to the low 16 bits
    function [15:0] merge16;
        input [15:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        input [15:0] mask;
        begin
            merge16 = old_v;
            if (be[0]) begin
                merge16[7:0] = new_v[7:0];
            end
            if (be[1]) begin
                merge16[15:8] = new_v[15:8];
            end
            merge16 = merge16 & mask;
        end
    endfunction

    // Word select from byte address
    function is_reg;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            is_reg = (addr[3:2] == ofs[3:2]);
        end
    endfunction

    // Next values of line and engine outputs
    reg rts_pin_nxt;
    reg dtr_pin_nxt;
    reg outa_pin_nxt;
    reg outb_pin_nxt;
    reg cts_nxt;
    reg dsr_nxt;
    reg dcd_nxt;
    reg ri_nxt;
    reg rxd_nxt;
    reg sir_in_nxt;
    reg txd_pin_nxt;
    reg sir_out_nxt;
    reg [15:0] status_nxt;

    always @* begin
        // Handshake pins are complements of their bits, except RTS under flow control
        if (request_to_send_flow_en) begin
            rts_pin_nxt = ~rx_fifo_room; // RL3
        end else begin
            rts_pin_nxt = ~serial_control_reg_r[`UFL_CR_RTS]; // RL6
        end
        dtr_pin_nxt  = ~serial_control_reg_r[`UFL_CR_DTR]; // RL7
        outa_pin_nxt = ~aux_modem_output_a; // RL5
        outb_pin_nxt = ~aux_modem_output_b; // RL4

        // Modem status as seen by the engine, active high
        if (loopback_enable) begin
            cts_nxt = ~rts_pin_nxt; // RL14
            dsr_nxt = ~dtr_pin_nxt; // RL14
            dcd_nxt = ~outa_pin_nxt; // RL14
            ri_nxt  = ~outb_pin_nxt; // RL14
        end else if (sir_en_w) begin
            cts_nxt = cts_seen; // RL17
            dsr_nxt = dsr_seen; // RL17
            dcd_nxt = dcd_seen; // RL17
            ri_nxt  = ri_seen; // RL17
        end else begin
            cts_nxt = ~clear_to_send_pin_n;
            dsr_nxt = ~data_set_ready_pin_n;
            dcd_nxt = ~carrier_detect_pin_n;
            ri_nxt  = ~ring_indicator_pin_n;
        end

        // Receive path selection
        if (loopback_enable && !infrared_test_override) begin
            rxd_nxt = core_txd; // RL13
        end else if (sir_en_w) begin
            rxd_nxt = 1'b1; // RL17
        end else begin
            rxd_nxt = serial_rx_pin; // RL8
        end
        if (loopback_enable && sir_en_w && infrared_test_override) begin
            sir_in_nxt = ~core_sir_out_n; // RL12
        end else if (sir_en_w) begin
            sir_in_nxt = infrared_in; // RL8
        end else begin
            sir_in_nxt = 1'b0;
        end

        // Transmit path selection; wired line marks in infrared mode
        txd_pin_nxt = sir_en_w ? 1'b1 : core_txd; // RL9 RL17
        sir_out_nxt = sir_en_w ? core_sir_out_n : 1'b0; // RL9

        status_nxt                 = 16'h0000;
        status_nxt[`UFL_ST_TX_RUN] = tx_run;
        status_nxt[`UFL_ST_RX_RUN] = rx_run;
        status_nxt[`UFL_ST_TX_ACT] = tx_char_active;
        status_nxt[`UFL_ST_RX_ACT] = rx_char_active;
        status_nxt[`UFL_ST_CTS]    = cts_seen;
        status_nxt[`UFL_ST_DSR]    = dsr_seen;
        status_nxt[`UFL_ST_DCD]    = dcd_seen;
        status_nxt[`UFL_ST_RI]     = ri_seen;
    end

    // Direction enables; index 0 transmit, 1 receive
    assign run_en_w[0] = transmitter_enable & port_enable &
                         (~clear_to_send_flow_en | cts_seen); // RL2 RL16
    assign run_en_w[1] = receiver_enable & port_enable; // RL16
    assign active_w[0] = tx_char_active;
    assign active_w[1] = rx_char_active;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_dir
            ufl_run_gate u_gate (
                .clk         (clk),
                .resetn      (resetn),
                .enable      (run_en_w[gi]),
                .char_active (active_w[gi]),
                .run_r       (run_w[gi])
            ); // RL10 RL11
        end
    endgenerate

    // Bus slave: one wait cycle, then completion
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitrequest               <= 1'b1;
            readdata                  <= 32'h00000000;
            serial_control_reg_r      <= `UFL_CR_RESET; // RL1
            serial_test_control_reg_r <= `UFL_TCR_RESET;
        end else begin
            waitrequest <= ~(access_w & waitrequest);
            if (read && waitrequest) begin
                if (is_reg(address, `UFL_OFS_CTRL)) begin
                    readdata <= {16'h0000, serial_control_reg_r};
                end else if (is_reg(address, `UFL_OFS_TEST)) begin
                    readdata <= {16'h0000, serial_test_control_reg_r};
                end else if (is_reg(address, `UFL_OFS_STATUS)) begin
                    readdata <= {16'h0000, status_nxt};
                end else begin
                    readdata <= 32'h00000000;
                end
            end
            if (take_w && write) begin
                if (is_reg(address, `UFL_OFS_CTRL)) begin
                    serial_control_reg_r <= merge16(serial_control_reg_r, writedata,
                                                    byteenable, `UFL_CR_MASK);
                end else if (is_reg(address, `UFL_OFS_TEST)) begin
                    serial_test_control_reg_r <= merge16(serial_test_control_reg_r,
                                                         writedata, byteenable,
                                                         `UFL_TCR_MASK); // RL15
                end
            end
        end
    end

    // Registered line and engine outputs
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            request_to_send_pin_n <= 1'b1;
            terminal_ready_pin_n  <= 1'b1;
            aux_output_a_pin_n    <= 1'b1;
            aux_output_b_pin_n    <= 1'b1;
            cts_seen              <= 1'b0;
            dsr_seen              <= 1'b0;
            dcd_seen              <= 1'b0;
            ri_seen               <= 1'b0;
            core_rxd              <= 1'b1;
            core_sir_in           <= 1'b0;
            serial_tx_pin         <= 1'b1;
            infrared_out_n        <= 1'b0;
            tx_run                <= 1'b0;
            rx_run                <= 1'b0;
            infrared_path_enable  <= 1'b0;
            infrared_low_power    <= 1'b0;
        end else begin
            request_to_send_pin_n <= rts_pin_nxt;
            terminal_ready_pin_n  <= dtr_pin_nxt;
            aux_output_a_pin_n    <= outa_pin_nxt;
            aux_output_b_pin_n    <= outb_pin_nxt;
            cts_seen              <= cts_nxt;
            dsr_seen              <= dsr_nxt;
            dcd_seen              <= dcd_nxt;
            ri_seen               <= ri_nxt;
            core_rxd              <= rxd_nxt;
            core_sir_in           <= sir_in_nxt;
            serial_tx_pin         <= txd_pin_nxt;
            infrared_out_n        <= sir_out_nxt;
            tx_run                <= run_w[0]; // RL9
            rx_run                <= run_w[1]; // RL8
            infrared_path_enable  <= sir_en_w & port_enable;
            infrared_low_power    <= serial_control_reg_r[`UFL_CR_SIRLP];
        end
    end
endmodule

`default_nettype wire

// *** ufl_chk.sv ***
// Assertions on the serial control block's ports.
// Assumes writes land on the edge where waitrequest is sampled low.
`timescale 1ns/1ps
`default_nettype none
module ufl_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Register bus
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Engine side
    input wire logic        core_txd,
    input wire logic        core_rxd,
    input wire logic        tx_char_active,
    input wire logic        rx_char_active,
    input wire logic        tx_run,
    input wire logic        rx_run,
    input wire logic        cts_seen,
    input wire logic        infrared_path_enable,
    // Pins
    input wire logic        serial_tx_pin,
    input wire logic        clear_to_send_pin_n,
    input wire logic        request_to_send_pin_n,
    input wire logic        terminal_ready_pin_n,
    input wire logic        aux_output_a_pin_n,
    input wire logic        aux_output_b_pin_n
);
    logic [15:0] cr;
    logic        lb_test;
    wire         acc = write && !waitrequest;
    // Shadow of control and test registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cr      <= 16'h0300;
            lb_test <= 1'b0;
        end else if (acc && address[3:2] == 2'h0) begin
            if (byteenable[0])
                cr[7:0] <= writedata[7:0] & 8'h87;
            if (byteenable[1])
                cr[15:8] <= writedata[15:8];
        end else if (acc && address[3:2] == 2'h1 && byteenable[0]) begin
            lb_test <= writedata[2];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_ctrl_read: assert property (read && !waitrequest && address[3:2] == 2'h0
        |-> readdata == {16'h0000, cr}) else $error("control readback wrong");
    chk_dtr_level: assert property (terminal_ready_pin_n == !$past(cr[10]))
        else $error("terminal ready pin wrong");
    chk_aux_a_level: assert property (aux_output_a_pin_n == !$past(cr[12]))
        else $error("aux a pin wrong");
    chk_aux_b_level: assert property (aux_output_b_pin_n == !$past(cr[13]))
        else $error("aux b pin wrong");
    chk_rts_soft: assert property (!$past(cr[14])
        |-> request_to_send_pin_n == !$past(cr[11])) else $error("rts pin wrong");
    chk_cts_block: assert property ((cr[15] && !cr[7] && !cr[1] && clear_to_send_pin_n
        && !tx_run && !tx_char_active) [*4] |=> !tx_run) else $error("tx ran without cts");
    chk_tx_finish: assert property (tx_run && tx_char_active |=> tx_run)
        else $error("tx stopped mid character");
    chk_rx_finish: assert property (rx_run && rx_char_active |=> rx_run)
        else $error("rx stopped mid character");
    chk_rx_enable: assert property ($rose(rx_run) |-> $past(cr[9] && cr[0]))
        else $error("rx ran while disabled");
    chk_loop_data: assert property ($past(cr[7]) && !$past(lb_test)
        |-> core_rxd == $past(core_txd)) else $error("loopback data wrong");
    chk_loop_modem: assert property ($past(cr[7])
        |-> cts_seen == !request_to_send_pin_n) else $error("loopback modem wrong");
    chk_ir_idle: assert property (infrared_path_enable |-> serial_tx_pin)
        else $error("wired tx not idle");
endmodule
bind ufl_serial_ctrl ufl_chk u_chk (.clk, .resetn, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .core_txd, .core_rxd, .tx_char_active,
    .rx_char_active, .tx_run, .rx_run, .cts_seen, .infrared_path_enable, .serial_tx_pin,
    .clear_to_send_pin_n, .request_to_send_pin_n, .terminal_ready_pin_n,
    .aux_output_a_pin_n, .aux_output_b_pin_n);
`default_nettype wire

// *** ufl_modem.sv ***
// Remote modem model on the handshake lines.
// Assumes the bench sets ready and slow; answers DTR with DSR.
`timescale 1ns/1ps
`default_nettype none
module ufl_modem (
    // Clock
    input wire logic clk,
    // Bench control
    input wire logic ready,
    input wire logic slow,
    // Handshake lines
    input wire logic dtr_n,
    output wire      cts_n,
    output wire      dsr_n
);
    logic [2:0] dly = 3'h0;
    always @(posedge clk) begin
        dly <= {dly[1:0], ready};
    end
    // Slow mode grants clear-to-send three cycles late
    assign cts_n = !(slow ? dly[2] : ready);
    assign dsr_n = dtr_n;
endmodule
`default_nettype wire

// *** tb.sv ***
// Testbench for the serial control block.
// Assumes one wait cycle per bus request and registered outputs.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0;
    logic [3:0] address = 4'h0, byteenable = 4'h3;
    logic [31:0] writedata = 32'h0, rv;
    logic core_txd = 1'b1, core_sir_out_n = 1'b1, tx_char_active = 1'b0;
    logic rx_char_active = 1'b0, rx_fifo_room = 1'b1, ready = 1'b0, slow = 1'b1;
    logic serial_rx_pin = 1'b1, infrared_in = 1'b0;
    wire infrared_out_n, dsr_seen, infrared_low_power;
    wire [31:0] readdata;
    wire waitrequest, core_rxd, core_sir_in, tx_run, rx_run, cts_seen, serial_tx_pin;
    wire request_to_send_pin_n, terminal_ready_pin_n, aux_output_a_pin_n, aux_output_b_pin_n;
    wire clear_to_send_pin_n, data_set_ready_pin_n, infrared_path_enable;
    int num_errors = 0, tests_run = 0;
    always #20 clk = ~clk;
    ufl_serial_ctrl dut (.clk, .resetn, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .core_txd, .core_sir_out_n, .tx_char_active, .rx_char_active,
        .rx_fifo_room, .core_rxd, .core_sir_in, .tx_run, .rx_run, .cts_seen, .dsr_seen,
        .dcd_seen(), .ri_seen(), .infrared_path_enable, .infrared_low_power,
        .serial_rx_pin, .infrared_in, .clear_to_send_pin_n, .data_set_ready_pin_n,
        .carrier_detect_pin_n(1'b1), .ring_indicator_pin_n(1'b1), .serial_tx_pin,
        .infrared_out_n, .request_to_send_pin_n, .terminal_ready_pin_n, .aux_output_a_pin_n,
        .aux_output_b_pin_n);
    ufl_modem u_modem (.clk, .ready, .slow, .dtr_n(terminal_ready_pin_n),
        .cts_n(clear_to_send_pin_n), .dsr_n(data_set_ready_pin_n));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        check("bus answer", 1'b1, n < 50);
        rv = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic t_reset;
        bus(0, 4'h0, 0);
        check("control", 32'h0300, rv);
        bus(0, 4'h4, 0);
        check("test", 0, rv);
        bus(0, 4'hc, 0);
        check("unmapped", 0, rv);
        check("pins", 4'hf, {aux_output_b_pin_n, aux_output_a_pin_n,
            request_to_send_pin_n, terminal_ready_pin_n});
        check("run", 0, {tx_run, rx_run});
    endtask
    task automatic t_pins;
        for (int i = 10; i < 14; i++) begin
            bus(1, 4'h0, 32'h1 << i);
            repeat (2) @(posedge clk);
            check("pins", ~(4'h1 << (i - 10)) & 4'hf, {aux_output_b_pin_n, aux_output_a_pin_n,
                request_to_send_pin_n, terminal_ready_pin_n});
        end
        rx_fifo_room <= 1'b0;
        bus(1, 4'h0, 32'h4800);
        repeat (2) @(posedge clk);
        check("rts full", 1, request_to_send_pin_n);
        rx_fifo_room <= 1'b1;
        repeat (2) @(posedge clk);
        check("rts room", 0, request_to_send_pin_n);
    endtask
    task automatic t_gate;
        int n;
        bus(1, 4'h0, 32'h0300);
        repeat (6) @(posedge clk);
        check("port off", 0, {tx_run, rx_run});
        bus(1, 4'h0, 32'h8301);
        repeat (10) @(posedge clk);
        check("no cts", 2'h1, {tx_run, rx_run});
        ready <= 1'b1;
        for (n = 0; n < 20 && tx_run !== 1'b1; n++) @(posedge clk);
        check("cts run", 1, tx_run);
        tx_char_active <= 1'b1;
        rx_char_active <= 1'b1;
        bus(1, 4'h0, 32'h0000);
        repeat (6) @(posedge clk);
        check("finish", 2'h3, {tx_run, rx_run});
        tx_char_active <= 1'b0;
        rx_char_active <= 1'b0;
        ready <= 1'b0;
        repeat (4) @(posedge clk);
        check("stopped", 0, {tx_run, rx_run});
    endtask
    task automatic t_loop;
        bus(1, 4'h0, 32'h0c81);
        core_txd <= 1'b0;
        repeat (2) @(posedge clk);
        check("loop cts", 1, cts_seen);
        check("loop rxd", 0, core_rxd);
        bus(1, 4'h4, 32'h4);
        bus(1, 4'h0, 32'h0083);
        core_sir_out_n <= 1'b0;
        repeat (3) @(posedge clk);
        check("ir loop", 1, core_sir_in);
        check("tx idle", 1, serial_tx_pin);
        core_sir_out_n <= 1'b1;
        core_txd <= 1'b1;
        bus(1, 4'h4, 0);
        bus(1, 4'h0, 0);
    endtask
    // Wired and infrared line paths, frozen modem status in infrared mode
    task automatic t_lines;
        bus(1, 4'h0, 32'h0701);
        serial_rx_pin <= 1'b0;
        repeat (3) @(posedge clk);
        check("rx pin", 0, core_rxd);
        check("ir out off", 0, infrared_out_n);
        bus(0, 4'h8, 0);
        check("dsr status", 1, rv[5]);
        bus(1, 4'h0, 32'h0307);
        infrared_in <= 1'b1;
        repeat (3) @(posedge clk);
        check("ir rx", 1, core_sir_in);
        check("ir rxd idle", 1, core_rxd);
        check("ir tx", 1, infrared_out_n);
        check("ir low power", 1, infrared_low_power);
        check("dsr frozen", 1, dsr_seen);
        serial_rx_pin <= 1'b1;
        infrared_in <= 1'b0;
        bus(1, 4'h0, 0);
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_pins();
        t_gate();
        t_loop();
        t_lines();
        final_report();
    end
endmodule
`default_nettype wire
